// >>> src/gic_consts.vh
// Constants of the pin and interrupt-output control block.
// Assumes one 250 MHz core clock; included by bare name.
`ifndef GIC_CONSTS_VH
`define GIC_CONSTS_VH

// Register word offsets (10-bit register address)
`define GIC_OFF_CTRL       10'h000
`define GIC_OFF_LOW_EN     10'h005
`define GIC_OFF_HIGH_EN    10'h006
`define GIC_OFF_DONE_EN    10'h007
`define GIC_OFF_LOW_FLAGS  10'h008
`define GIC_OFF_HIGH_FLAGS 10'h009
`define GIC_OFF_DONE_FLAGS 10'h00a

// Field positions
`define GIC_NSTAGE         12
`define GIC_EXC_DIS_BIT    12
`define GIC_EXC_N_DIS_BIT  13
`define GIC_DIR_LSB        12
`define GIC_DIR_MSB        13
`define GIC_TRIG_LSB       14
`define GIC_TRIG_MSB       15
`define GIC_PIN_EN_BIT     12
`define GIC_PIN_STAT_BIT   12

// Pin direction codes
`define GIC_DIR_OFF        2'h0
`define GIC_DIR_IN         2'h1
`define GIC_DIR_LOW        2'h2
`define GIC_DIR_HIGH       2'h3

// Pin trigger codes
`define GIC_TRIG_LOW_LVL   2'h0
`define GIC_TRIG_RISE      2'h1
`define GIC_TRIG_FALL      2'h2
`define GIC_TRIG_HIGH_LVL  2'h3

// Reset values
`define GIC_RST_WORD       16'h0000
`define GIC_RST_FLAGS      12'h000
`define GIC_RST_DONE       13'h0000

// Timing: excitation rate and derived half-period count
`define GIC_CLK_HZ         250000000
`define GIC_EXC_HZ         250000
`define GIC_EXC_HALF       (`GIC_CLK_HZ / (2 * `GIC_EXC_HZ))
// Last count of a half period, sized; keep equal to GIC_EXC_HALF - 1
`define GIC_EXC_HALF_LAST  10'h1f3

`endif

// >>> src/gic_sync2.v
// Two-stage synchroniser for one asynchronous level.
// Assumes the input may change at any time against core_clk.
`timescale 1ns/1ps
module gic_sync2 (
  // Clock and reset
  input  wire core_clk,
  input  wire srst,
  // Level in and out
  input  wire async_in,
  output reg  sync_out
);

  reg meta_reg;  // First stage, read only by second

  // Two flops in series
  always @(posedge core_clk) begin
    if (srst) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// >>> src/gic_exc_gen.v
// Excitation square-wave generator with separate output disables.
// Assumes core_clk at the rate given in the constants header.
`timescale 1ns/1ps
`include "gic_consts.vh"
module gic_exc_gen (
  // Clock and reset
  input  wire core_clk,
  input  wire srst,
  // Disables from the control register
  input  wire dis_true,
  input  wire dis_inv,
  // Excitation pins
  output reg  exc_out,
  output reg  exc_n_out
);

  localparam [9:0] HALF_LAST = `GIC_EXC_HALF_LAST;  // Sized, no cast needed

  reg [9:0] div_reg;    // Half-period counter
  reg       wave_reg;   // Raw square wave
  wire      tick;       // One-cycle half-period enable

  assign tick = (div_reg == HALF_LAST);

  // Divider and wave toggle
  always @(posedge core_clk) begin
    if (srst) begin
      div_reg  <= 10'h000;
      wave_reg <= 1'b0;
    end else if (tick) begin
      div_reg  <= 10'h000;
      wave_reg <= ~wave_reg;
    end else begin
      div_reg  <= div_reg + 10'h001;
    end
  end

  // Gated outputs, held low when disabled
  always @(posedge core_clk) begin
    if (srst) begin
      exc_out   <= 1'b0;
      exc_n_out <= 1'b0;
    end else begin
      exc_out   <= wave_reg & ~dis_true;
      exc_n_out <= ~wave_reg & ~dis_inv;
    end
  end

endmodule

// >>> src/gic_pin_ctrl.v
// Pin and interrupt-output control: register file, pin
// direction, pin trigger, stage interrupt flags, excitation.
// Assumes a register port on core_clk from the serial
// interface, one-cycle read and write strobes, and stage
// event pulses from the sequencer on the same clock.
`timescale 1ns/1ps
`include "gic_consts.vh"

////////////////////////////////////////////////////////////
// Summary of operation
// - Input pin drives interrupt per trigger mode
// - Direction field: off, input, low, high
// - Output mode drives constant selected level
// - Pin interrupt enable bit at 0x007
// - Pin status bit set when pin interrupts
// - Read clears status only if condition gone
// - Trigger field: low, rise, fall, high
// - Low level holds interrupt while pin low
// - High level holds interrupt while pin high
// - Rising edge holds interrupt low until 0x00A read
// - Falling edge holds interrupt low until 0x00A read
// - Reading 0x00A releases pin interrupt unless a level trigger still holds
// - 250 kHz excitation, true and inverted
// - Control bit 12 disables true excitation
// - Control bit 13 disables inverted excitation
// - Status read clears on the read strobe
// - Per-stage low and high enables
// - Interrupt output active low, open drain
module gic_pin_ctrl (
  // Clock and reset
  input  wire        core_clk,
  input  wire        srst,

  // Register port
  input  wire [9:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,

  // Stage events from the sequencer
  input  wire [11:0] stage_done_evt,
  input  wire [11:0] stage_low_evt,
  input  wire [11:0] stage_high_evt,

  // General-purpose pin
  input  wire        gpio_pin_in,
  output reg         gpio_pin_out,
  output reg         gpio_pin_oe,

  // Interrupt pin, open drain
  output reg         irq_n_out,
  output reg         irq_n_oe,

  // Excitation pins
  output wire        exc_out,
  output wire        exc_n_out
);

  //////////////////////////////////////////////////////////
  // Decode helper

  // True when an access targets the given offset
  function addr_hit;
    input [9:0] addr;
    input [9:0] offs;
    begin
      addr_hit = (addr == offs);
    end
  endfunction

  //////////////////////////////////////////////////////////
  // Declarations

  // Software-written registers
  reg  [15:0] ctrl_reg;        // Control, excitation disables
  reg  [15:0] low_en_reg;      // Low enables, pin setup
  reg  [15:0] high_en_reg;     // High-threshold enables
  reg  [15:0] done_en_reg;     // Done enables, pin enable

  // Hardware-set flag registers
  reg  [11:0] low_flags_reg;   // Low-limit flags
  reg  [11:0] low_flags_next;  // Next low-limit flags
  reg  [11:0] high_flags_reg;  // High-limit flags
  reg  [11:0] high_flags_next; // Next high-limit flags
  reg  [12:0] done_flags_reg;  // Done flags plus pin status
  reg  [12:0] done_flags_next; // Next done flags

  // Pin input path
  wire        pin_sync;        // Synchronised pin level
  reg         pin_prev_reg;    // Previous synced level
  reg         pin_trig;        // Trigger condition this cycle
  wire        pin_is_in;       // Pin set up as input
  wire        pin_set;         // Pin status set request

  // Field views
  wire [1:0]  pin_dir;         // Direction field
  wire [1:0]  pin_trig_mode;   // Trigger field

  // Access strobes
  wire        rd_low;          // Read of low-limit flags
  wire        rd_high;         // Read of high-limit flags
  wire        rd_done;         // Read of done flags

  // Read data mux
  reg  [15:0] rd_mux;          // Word selected by address

  // Interrupt request level
  wire        irq_any;         // Any flag pending

  //////////////////////////////////////////////////////////
  // Field views and strobes

  assign pin_dir       = low_en_reg[`GIC_DIR_MSB:`GIC_DIR_LSB];
  assign pin_trig_mode = low_en_reg[`GIC_TRIG_MSB:`GIC_TRIG_LSB];

  assign pin_is_in = (pin_dir == `GIC_DIR_IN);

  assign rd_low  = reg_rd & addr_hit(reg_addr, `GIC_OFF_LOW_FLAGS);
  assign rd_high = reg_rd & addr_hit(reg_addr, `GIC_OFF_HIGH_FLAGS);
  assign rd_done = reg_rd & addr_hit(reg_addr, `GIC_OFF_DONE_FLAGS);

  //////////////////////////////////////////////////////////
  // Pin input synchroniser

  gic_sync2 u_pin_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in (gpio_pin_in),
    .sync_out (pin_sync)
  );

  // Previous level for edge detection
  always @(posedge core_clk) begin
    if (srst) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_sync;
    end
  end

  //////////////////////////////////////////////////////////
  // Pin trigger detection

  // Condition per trigger mode
  always @* begin
    pin_trig = 1'b0;
    case (pin_trig_mode)
      `GIC_TRIG_LOW_LVL: begin
        pin_trig = ~pin_sync;
      end
      `GIC_TRIG_RISE: begin
        pin_trig = pin_sync & ~pin_prev_reg;
      end
      `GIC_TRIG_FALL: begin
        pin_trig = ~pin_sync & pin_prev_reg;
      end
      default: begin
        pin_trig = pin_sync;
      end
    endcase
  end

  // Gated by the pin enable bit
  assign pin_set = pin_is_in & pin_trig &
                   done_en_reg[`GIC_PIN_EN_BIT];

  //////////////////////////////////////////////////////////
  // Pin drive

  // Output level and enable from direction
  always @(posedge core_clk) begin
    if (srst) begin
      gpio_pin_out <= 1'b0;
      gpio_pin_oe  <= 1'b0;
    end else begin
      case (pin_dir)
        `GIC_DIR_LOW: begin
          gpio_pin_out <= 1'b0;
          gpio_pin_oe  <= 1'b1;
        end
        `GIC_DIR_HIGH: begin
          gpio_pin_out <= 1'b1;
          gpio_pin_oe  <= 1'b1;
        end
        default: begin
          gpio_pin_out <= 1'b0;
          gpio_pin_oe  <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////
  // Register writes

  // Writable configuration registers
  always @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg    <= `GIC_RST_WORD;
      low_en_reg  <= `GIC_RST_WORD;
      high_en_reg <= `GIC_RST_WORD;
      done_en_reg <= `GIC_RST_WORD;
    end else if (reg_wr) begin
      if (addr_hit(reg_addr, `GIC_OFF_CTRL)) begin
        ctrl_reg <= reg_wdata;
      end else if (addr_hit(reg_addr, `GIC_OFF_LOW_EN)) begin
        low_en_reg <= reg_wdata;
      end else if (addr_hit(reg_addr, `GIC_OFF_HIGH_EN)) begin
        high_en_reg <= reg_wdata;
      end else if (addr_hit(reg_addr, `GIC_OFF_DONE_EN)) begin
        done_en_reg <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////
  // Flag next values; set wins over read clear

  always @* begin
    // Low flags cleared by 0x008 read
    low_flags_next = rd_low ? `GIC_RST_FLAGS : low_flags_reg;
    low_flags_next = low_flags_next |
                     (stage_low_evt &
                      low_en_reg[`GIC_NSTAGE-1:0]);

    high_flags_next = rd_high ? `GIC_RST_FLAGS : high_flags_reg;
    high_flags_next = high_flags_next |
                      (stage_high_evt &
                       high_en_reg[`GIC_NSTAGE-1:0]);

    // Read of 0x00A releases pin status
    done_flags_next = rd_done ? `GIC_RST_DONE : done_flags_reg;
    done_flags_next[`GIC_NSTAGE-1:0] =
      done_flags_next[`GIC_NSTAGE-1:0] |
      (stage_done_evt & done_en_reg[`GIC_NSTAGE-1:0]);
    // Pin status set on pin interrupt
    // Condition still present keeps it set
    done_flags_next[`GIC_PIN_STAT_BIT] =
      done_flags_next[`GIC_PIN_STAT_BIT] | pin_set;
  end

  // Flag registers
  always @(posedge core_clk) begin
    if (srst) begin
      low_flags_reg  <= `GIC_RST_FLAGS;
      high_flags_reg <= `GIC_RST_FLAGS;
      done_flags_reg <= `GIC_RST_DONE;
    end else begin
      low_flags_reg  <= low_flags_next;
      high_flags_reg <= high_flags_next;
      done_flags_reg <= done_flags_next;
    end
  end

  //////////////////////////////////////////////////////////
  // Register reads

  // Word selected by address; unmapped reads zero
  always @* begin
    rd_mux = 16'h0000;
    if (addr_hit(reg_addr, `GIC_OFF_CTRL)) begin
      rd_mux = ctrl_reg;
    end else if (addr_hit(reg_addr, `GIC_OFF_LOW_EN)) begin
      rd_mux = low_en_reg;
    end else if (addr_hit(reg_addr, `GIC_OFF_HIGH_EN)) begin
      rd_mux = high_en_reg;
    end else if (addr_hit(reg_addr, `GIC_OFF_DONE_EN)) begin
      rd_mux = done_en_reg;
    end else if (addr_hit(reg_addr, `GIC_OFF_LOW_FLAGS)) begin
      rd_mux = {4'h0, low_flags_reg};
    end else if (addr_hit(reg_addr, `GIC_OFF_HIGH_FLAGS)) begin
      rd_mux = {4'h0, high_flags_reg};
    end else if (addr_hit(reg_addr, `GIC_OFF_DONE_FLAGS)) begin
      rd_mux = {3'h0, done_flags_reg};
    end
  end

  // Read data captured on the read strobe
  always @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      // Value before the clear is returned
      reg_rdata <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////
  // Interrupt output

  // Pending from next flags, so release follows read
  assign irq_any = (|low_flags_next) |
                   (|high_flags_next) |
                   (|done_flags_next);

  // Open-drain drive: pull low while pending
  always @(posedge core_clk) begin
    if (srst) begin
      irq_n_out <= 1'b0;
      irq_n_oe  <= 1'b0;
    end else begin
      // Active low, only ever driven low
      irq_n_out <= 1'b0;
      // Released in the cycle after the read
      irq_n_oe  <= irq_any;
    end
  end

  //////////////////////////////////////////////////////////
  // Excitation source

  gic_exc_gen u_exc (
    .core_clk  (core_clk),
    .srst      (srst),
    .dis_true  (ctrl_reg[`GIC_EXC_DIS_BIT]),
    .dis_inv   (ctrl_reg[`GIC_EXC_N_DIS_BIT]),
    .exc_out   (exc_out),
    .exc_n_out (exc_n_out)
  );

endmodule

// >>> bench/gic_host_model.sv
// Host-side pads: pull-up on the interrupt line, pin pad.
// Assumes the bench drives the pin source when undriven.
`timescale 1ns/1ps
module gic_host_model (
  // Design drives
  input  wire irq_n_out,
  input  wire irq_n_oe,
  input  wire gpio_pin_out,
  input  wire gpio_pin_oe,
  // Outside source of the pin
  input  wire ext_pin,
  // Resolved lines
  output wire irq_line_n,
  output wire pin_pad
);
  assign irq_line_n = irq_n_oe ? irq_n_out : 1'b1;
  // Design drive wins over the outside source
  assign pin_pad = gpio_pin_oe ? gpio_pin_out : ext_pin;
endmodule

// >>> bench/gic_pin_ctrl_properties.sv
// Checker of the pin and interrupt-output block.
// Assumes it sees only the ports of the block.
`timescale 1ns/1ps
module gic_chk (
  // Clock and reset
  input wire        core_clk,
  input wire        srst,
  // Register port
  input wire [9:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  // Stage events
  input wire [11:0] stage_done_evt,
  input wire [11:0] stage_low_evt,
  input wire [11:0] stage_high_evt,
  // Pins
  input wire        gpio_pin_in,
  input wire        gpio_pin_out,
  input wire        gpio_pin_oe,
  input wire        irq_n_out,
  input wire        irq_n_oe,
  input wire        exc_out,
  input wire        exc_n_out
);
  reg  [15:0] cfg_reg;      // Copy of word 0x005
  reg  [11:0] hi_en_reg;    // Copy of word 0x006
  reg         pin_en_reg;   // Pin interrupt enable
  reg  [3:0]  hist_reg;     // Last four pin samples
  reg  [2:0]  age_reg;      // Cycles since a setup write
  wire        wr_cfg  = reg_wr && reg_addr == 10'h005;
  wire        wr_en   = reg_wr && reg_addr == 10'h007;
  wire        wr_ctl  = reg_wr && reg_addr == 10'h000;
  wire        settled = age_reg == 3'h4 && pin_en_reg;

  ////////////////////////////////////////////////////////////
  // Shadow copies of the setup words
  always @(posedge core_clk) begin
    if (srst) begin
      cfg_reg <= 16'h0000;
      hi_en_reg <= 12'h000;
      pin_en_reg <= 1'b0;
      hist_reg <= 4'h0;
      age_reg <= 3'h0;
    end else begin
      if (wr_cfg) cfg_reg <= reg_wdata;
      if (reg_wr && reg_addr == 10'h006) hi_en_reg <= reg_wdata[11:0];
      if (wr_en) pin_en_reg <= reg_wdata[12];
      hist_reg <= {hist_reg[2:0], gpio_pin_in};
      if (wr_cfg || wr_en) age_reg <= 3'h0;
      else if (age_reg != 3'h4) age_reg <= age_reg + 3'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_irq_od;
    irq_n_oe |-> !irq_n_out;
  endproperty
  a_irq_od: assert property (p_irq_od) else $error("irq driven high");
  // Register written at the first edge, pin flop follows one edge later
  property p_dir_low;
    wr_cfg && reg_wdata[13:12] == 2'h2 |-> ##2 gpio_pin_oe && !gpio_pin_out;
  endproperty
  a_dir_low: assert property (p_dir_low) else $error("pin not low");
  property p_dir_high;
    wr_cfg && reg_wdata[13:12] == 2'h3 |-> ##2 gpio_pin_oe && gpio_pin_out;
  endproperty
  a_dir_high: assert property (p_dir_high) else $error("pin not high");
  property p_dir_off;
    wr_cfg && !reg_wdata[13] |-> ##2 !gpio_pin_oe;
  endproperty
  a_dir_off: assert property (p_dir_off) else $error("pin driven");
  property p_exc_dis;
    wr_ctl && reg_wdata[12] |-> ##2 !exc_out;
  endproperty
  a_exc_dis: assert property (p_exc_dis) else $error("exc on");
  property p_exc_n_dis;
    wr_ctl && reg_wdata[13] |-> ##2 !exc_n_out;
  endproperty
  a_exc_n_dis: assert property (p_exc_n_dis) else $error("exc_n on");
  property p_low_evt;
    |(stage_low_evt & cfg_reg[11:0]) |=> irq_n_oe;
  endproperty
  a_low_evt: assert property (p_low_evt) else $error("low irq lost");
  property p_high_evt;
    |(stage_high_evt & hi_en_reg) |=> irq_n_oe;
  endproperty
  a_high_evt: assert property (p_high_evt) else $error("high irq lost");
  property p_lvl_lo;
    settled && cfg_reg[15:12] == 4'h1 && hist_reg == 4'h0 |-> irq_n_oe;
  endproperty
  a_lvl_lo: assert property (p_lvl_lo) else $error("low level lost");
  property p_lvl_hi;
    settled && cfg_reg[15:12] == 4'hd && hist_reg == 4'hf |-> irq_n_oe;
  endproperty
  a_lvl_hi: assert property (p_lvl_hi) else $error("high level lost");
endmodule

bind gic_pin_ctrl gic_chk u_chk (
  .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .stage_done_evt(stage_done_evt), .stage_low_evt(stage_low_evt),
  .stage_high_evt(stage_high_evt), .gpio_pin_in(gpio_pin_in),
  .gpio_pin_out(gpio_pin_out), .gpio_pin_oe(gpio_pin_oe), .irq_n_out(irq_n_out),
  .irq_n_oe(irq_n_oe), .exc_out(exc_out), .exc_n_out(exc_n_out)
);

// >>> bench/testbench.sv
// Testbench of the pin and interrupt-output block.
// Assumes the host model closes the interrupt and pin pads.
`timescale 1ns/1ps
module testbench;
  reg         core_clk;   // Core clock
  reg         srst;       // Synchronous reset
  reg  [9:0]  reg_addr;   // Register address
  reg         reg_wr;     // Write strobe
  reg         reg_rd;     // Read strobe
  reg  [15:0] reg_wdata;  // Write data
  reg  [11:0] done_evt;   // Stage events
  reg  [11:0] low_evt;
  reg  [11:0] high_evt;
  reg         ext_pin;    // Outside pin source
  reg  [1:0]  tc;         // Direction or trigger code in test
  wire [15:0] reg_rdata;
  wire        pin_out, pin_oe, irq_out, irq_oe, exc, exc_n, irq_line_n, pin_pad;
  integer     mismatches, n_compared, cyc, t;

  gic_pin_ctrl dut (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .stage_done_evt(done_evt), .stage_low_evt(low_evt), .stage_high_evt(high_evt),
    .gpio_pin_in(pin_pad), .gpio_pin_out(pin_out), .gpio_pin_oe(pin_oe),
    .irq_n_out(irq_out), .irq_n_oe(irq_oe), .exc_out(exc), .exc_n_out(exc_n)
  );
  gic_host_model u_host (
    .irq_n_out(irq_out), .irq_n_oe(irq_oe), .gpio_pin_out(pin_out),
    .gpio_pin_oe(pin_oe), .ext_pin(ext_pin), .irq_line_n(irq_line_n), .pin_pad(pin_pad)
  );

  ////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end

  task summarize;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // Register write, strobe one cycle
  task wr(input [9:0] a, input [15:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
    end
  endtask
  // Register read and compare
  task rdc(input [9:0] a, input [15:0] e);
    begin
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      chk(reg_rdata, e);
      tick(1);
    end
  endtask
  // High cycles and rises over one excitation period
  task exc_count(input [15:0] et, input [15:0] en, input [15:0] er);
    reg [15:0] h, nh, r;
    reg        p;
    begin
      tick(2);
      h = 0;
      nh = 0;
      r = 0;
      p = exc;
      // Step once so that all 1000 pairs span a whole period
      tick(1);
      repeat (1000) begin
        h = h + exc;
        nh = nh + exc_n;
        r = r + (exc & !p);
        p = exc;
        tick(1);
      end
      chk(h, et);
      chk(nh, en);
      chk(r, er);
    end
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    reg_addr = 10'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
    done_evt = 12'h000;
    low_evt = 12'h000;
    high_evt = 12'h000;
    ext_pin = 1'b1;
    mismatches = 0;
    n_compared = 0;
    cyc = 0;
    repeat (8) @(posedge core_clk);
    #1;
    srst = 1'b0;
    chk(pin_oe, 1'b0);
    chk(irq_line_n, 1'b1);
    rdc(10'h005, 16'h0000);
    rdc(10'h00a, 16'h0000);
    wr(10'h3ff, 16'hffff);
    rdc(10'h3ff, 16'h0000);
    wr(10'h006, 16'h0abc);
    rdc(10'h006, 16'h0abc);
    wr(10'h005, 16'h0001);
    wr(10'h007, 16'h0008);
    // Stage events, enabled and masked bits together for low and done
    low_evt = 12'h003;
    tick(1);
    low_evt = 12'h000;
    chk(irq_line_n, 1'b0);
    rdc(10'h008, 16'h0001);
    chk(irq_line_n, 1'b1);
    done_evt = 12'h018;
    tick(1);
    done_evt = 12'h000;
    chk(irq_line_n, 1'b0);
    rdc(10'h00a, 16'h0008);
    rdc(10'h00a, 16'h0000);
    high_evt = 12'h800;
    tick(1);
    high_evt = 12'h000;
    chk(irq_line_n, 1'b0);
    rdc(10'h009, 16'h0800);
    chk(irq_line_n, 1'b1);
    // Output drive modes
    for (t = 2; t < 4; t = t + 1) begin
      tc = t[1:0];
      wr(10'h005, {2'b00, tc, 12'h000});
      chk(pin_oe, 1'b1);
      chk(pin_pad, tc[0]);
    end
    wr(10'h005, 16'h0000);
    chk(pin_oe, 1'b0);
    // Disabled pin, then input with interrupt masked
    wr(10'h007, 16'h1000);
    ext_pin = 1'b0;
    tick(6);
    chk(irq_line_n, 1'b1);
    rdc(10'h00a, 16'h0000);
    ext_pin = 1'b1;
    wr(10'h007, 16'h0000);
    wr(10'h005, 16'h1000);
    ext_pin = 1'b0;
    tick(6);
    chk(irq_line_n, 1'b1);
    rdc(10'h00a, 16'h0000);
    ext_pin = 1'b1;
    tick(4);
    wr(10'h007, 16'h1000);
    // Every trigger code
    for (t = 0; t < 4; t = t + 1) begin
      tc = t[1:0];
      wr(10'h005, 16'h0000);
      ext_pin = !tc[0];
      tick(4);
      wr(10'h005, {tc, 2'b01, 12'h000});
      tick(4);
      rdc(10'h00a, 16'h0000);
      ext_pin = tc[0];
      tick(4);
      chk(irq_line_n, 1'b0);
      rdc(10'h00a, 16'h1000);
      if (tc == 2'h0 || tc == 2'h3) begin
        chk(irq_line_n, 1'b0);
        ext_pin = !tc[0];
        tick(4);
        rdc(10'h00a, 16'h1000);
      end else begin
        chk(irq_line_n, 1'b1);
        ext_pin = !tc[0];
        tick(4);
      end
      rdc(10'h00a, 16'h0000);
      chk(irq_line_n, 1'b1);
    end
    // Excitation rate and separate disables
    wr(10'h000, 16'h0000);
    exc_count(16'h01f4, 16'h01f4, 16'h0001);
    chk(exc_n, !exc);
    wr(10'h000, 16'h1000);
    exc_count(16'h0000, 16'h01f4, 16'h0000);
    wr(10'h000, 16'h2000);
    exc_count(16'h01f4, 16'h0000, 16'h0001);
    summarize;
  end
endmodule
